// File: verilog/ilc_pkg.sv
`default_nettype none
package ilc_pkg;
  // Register offsets of the captured link configuration (byte-wide registers).
  localparam logic [11:0] OFS_FRAMES_PER_MF = 12'h405;
  localparam logic [11:0] OFS_CONV_COUNT = 12'h406;
  localparam logic [11:0] OFS_CTRL_RES = 12'h407;
  localparam logic [11:0] OFS_SUBCLASS_NP = 12'h408;
  localparam logic [11:0] OFS_VERSION_S = 12'h409;
  localparam logic [11:0] OFS_DENSITY_CF = 12'h40A;
  localparam logic [11:0] OFS_RES_ONE = 12'h40B;
  localparam logic [11:0] OFS_RES_TWO = 12'h40C;
  localparam logic [11:0] OFS_RX_CHECKSUM = 12'h40D;
  localparam logic [11:0] OFS_CALC_CHECKSUM = 12'h40E;
  localparam logic [11:0] OFS_LANE1_ID = 12'h412;
  localparam logic [11:0] OFS_LANE_CODE = 12'h403;
  localparam logic [11:0] OFS_FRAME_OCTETS = 12'h404;
  // Controller registers on APB (byte addresses).
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_CFG0 = 12'h004;
  localparam logic [11:0] APB_CFG1 = 12'h008;
  localparam logic [11:0] APB_CFG2 = 12'h00C;
  localparam logic [11:0] APB_STATUS = 12'h010;
  localparam logic [11:0] APB_RDATA = 12'h014;
  // Configuration octet positions within the alignment sequence (octet index).
  localparam int unsigned CFG_OCTETS = 14;
  localparam logic [3:0] OCT_LID = 4'h2;
  localparam logic [3:0] OCT_L = 4'h3;
  localparam logic [3:0] OCT_F = 4'h4;
  localparam logic [3:0] OCT_K = 4'h5;
  localparam logic [3:0] OCT_M = 4'h6;
  localparam logic [3:0] OCT_CS_N = 4'h7;
  localparam logic [3:0] OCT_SUB_NP = 4'h8;
  localparam logic [3:0] OCT_VER_S = 4'h9;
  localparam logic [3:0] OCT_HD_CF = 4'hA;
  localparam logic [3:0] OCT_RES1 = 4'hB;
  localparam logic [3:0] OCT_RES2 = 4'hC;
  localparam logic [3:0] OCT_FCHK = 4'hD;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Encodings.
  localparam logic [4:0] K_16 = 5'h0F;
  localparam logic [4:0] K_32 = 5'h1F;
  localparam logic [7:0] M_REAL = 8'h00;
  localparam logic [7:0] M_COMPLEX = 8'h01;
  localparam logic [4:0] L_ONE = 5'h00;
  localparam logic [4:0] L_TWO = 5'h01;
  localparam logic [4:0] L_FOUR = 5'h03;
  localparam logic [4:0] L_EIGHT = 5'h07;
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [2:0] VERSION_A = 3'h0;
  localparam logic [2:0] VERSION_B = 3'h1;
endpackage
`default_nettype wire

// File: verilog/ilc_link_if.sv
`default_nettype none
interface ilc_link_if;
  // Lane 0 octet stream during the alignment sequence.
  logic lane0_valid;
  logic lane0_start;
  logic [7:0] lane0_octet;
  // Lane 1 octet stream during the alignment sequence.
  logic lane1_valid;
  logic lane1_start;
  logic [7:0] lane1_octet;
  // Register read port of the receiver.
  logic [11:0] reg_addr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_ack;

  modport rx (
    input lane0_valid, lane0_start, lane0_octet,
    input lane1_valid, lane1_start, lane1_octet,
    input reg_addr, reg_rd,
    output reg_rdata, reg_ack
  );
  modport tx (
    output lane0_valid, lane0_start, lane0_octet,
    output lane1_valid, lane1_start, lane1_octet,
    output reg_addr, reg_rd,
    input reg_rdata, reg_ack
  );
endinterface
`default_nettype wire

// File: verilog/ilc_receiver.sv
// Operation
// - Store frames per multiframe minus one, 5 bits.
// - Store converter count minus one, 8 bits.
// - Transmitter advertises zero control bits per sample.
// - Store resolution minus one, 5 bits.
// - Store total sample bits minus one.
// - Capture subclass version, 3 bits.
// - Capture standard version, 3 bits.
// - Store samples per converter minus one.
// - Capture density flag in one bit.
// - Capture control words count; transmitter sends zero.
// - Capture both reserved octets unchanged.
// - Capture lane 0 received checksum octet.
// - Compute checksum by selected mode; must match.
// - Capture lane 1 identifier; upper bits zero.
// - Store octets per frame minus one.
// - Store lane count code, 5 bits.
`default_nettype none
module ilc_receiver (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Checksum method select.
  input wire logic CHECKSUM_MODE,
  // Link side.
  ilc_link_if.rx LINK,
  // Capture status.
  output logic CAPTURE_DONE,
  output logic CHECKSUM_OK
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] idx_reg;
  logic active_reg;
  logic [7:0] oct_reg [0:ilc_pkg::CFG_OCTETS-1];
  logic [7:0] lane1_received_identifier;
  logic [7:0] calc_reg;
  logic done_reg;
  logic [11:0] sum_fields;
  logic [7:0] sum_octets;
  logic [7:0] calc_next;
  logic [7:0] rdata_next;

  // Octet counter restarts on each sequence start; octet 0 arrives with start.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idx_reg <= 4'h0;
      active_reg <= 1'b0;
    end else if (LINK.lane0_valid && LINK.lane0_start) begin
      idx_reg <= 4'h1;
      active_reg <= 1'b1;
    end else if (LINK.lane0_valid && active_reg) begin
      idx_reg <= idx_reg + 4'h1;
      active_reg <= (idx_reg != ilc_pkg::OCT_FCHK);
    end
  end

  // Raw octets land in place; fields are cut out of them on read.
  genvar g;
  generate
    for (g = 0; g < ilc_pkg::CFG_OCTETS; g++) begin : g_oct
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          oct_reg[g] <= ilc_pkg::RESET_BYTE;
        end else if (LINK.lane0_valid && ((LINK.lane0_start && g == 0) ||
                     (active_reg && !LINK.lane0_start && idx_reg == 4'(g)))) begin
          oct_reg[g] <= LINK.lane0_octet;
        end
      end
    end
  endgenerate

  // Lane 1 identifier sits in the third octet of its own sequence.
  logic [3:0] idx1_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idx1_reg <= 4'h0;
      lane1_received_identifier <= ilc_pkg::RESET_BYTE;
    end else if (LINK.lane1_valid) begin
      idx1_reg <= LINK.lane1_start ? 4'h1 : ((idx1_reg == 4'hF) ? idx1_reg : idx1_reg + 4'h1);
      if (!LINK.lane1_start && idx1_reg == ilc_pkg::OCT_LID) begin
        lane1_received_identifier <= {3'h0, LINK.lane1_octet[4:0]};
      end
    end
  end

  // Mode 0 sums the fields, mode 1 sums whole octets 0 to 10; both modulo 256.
  always_comb begin
    sum_fields = 12'h000;
    sum_octets = 8'h00;
    for (int i = 0; i < 11; i++) begin
      sum_octets = sum_octets + oct_reg[i];
    end
    sum_fields = 12'(oct_reg[0]) + 12'(oct_reg[1]) + 12'(oct_reg[2][4:0]) +
                 12'(oct_reg[2][5]) + 12'(oct_reg[2][6]) + 12'(oct_reg[3][4:0]) +
                 12'(oct_reg[3][7]) + 12'(oct_reg[4]) + 12'(oct_reg[5][4:0]) +
                 12'(oct_reg[6]) + 12'(oct_reg[7][7:6]) + 12'(oct_reg[7][4:0]) +
                 12'(oct_reg[8][7:5]) + 12'(oct_reg[8][4:0]) + 12'(oct_reg[9][7:5]) +
                 12'(oct_reg[9][4:0]) + 12'(oct_reg[10][7]) + 12'(oct_reg[10][4:0]);
    calc_next = CHECKSUM_MODE ? sum_octets : sum_fields[7:0];
  end

  // The sum is frozen one cycle after the checksum octet so all inputs settled.
  logic fin_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fin_reg <= 1'b0;
      calc_reg <= ilc_pkg::RESET_BYTE;
      done_reg <= 1'b0;
      CAPTURE_DONE <= 1'b0;
      CHECKSUM_OK <= 1'b0;
    end else begin
      fin_reg <= LINK.lane0_valid && active_reg && !LINK.lane0_start &&
                 idx_reg == ilc_pkg::OCT_FCHK;
      if (fin_reg) begin
        calc_reg <= calc_next;
        done_reg <= 1'b1;
      end else if (LINK.lane0_valid && LINK.lane0_start) begin
        done_reg <= 1'b0;
      end
      CAPTURE_DONE <= done_reg;
      CHECKSUM_OK <= done_reg && (calc_reg == oct_reg[13]);
    end
  end

  // Read-only decode; there is no write path, so writes cannot disturb fields.
  always_comb begin
    case (LINK.reg_addr)
      ilc_pkg::OFS_FRAMES_PER_MF: rdata_next = {3'h0, oct_reg[5][4:0]};
      ilc_pkg::OFS_CONV_COUNT: rdata_next = oct_reg[6];
      ilc_pkg::OFS_CTRL_RES: rdata_next = {oct_reg[7][7:6], 1'b0, oct_reg[7][4:0]};
      ilc_pkg::OFS_SUBCLASS_NP: rdata_next = oct_reg[8];
      ilc_pkg::OFS_VERSION_S: rdata_next = oct_reg[9];
      ilc_pkg::OFS_DENSITY_CF: rdata_next = {oct_reg[10][7], 2'h0, oct_reg[10][4:0]};
      ilc_pkg::OFS_RES_ONE: rdata_next = oct_reg[11];
      ilc_pkg::OFS_RES_TWO: rdata_next = oct_reg[12];
      ilc_pkg::OFS_RX_CHECKSUM: rdata_next = oct_reg[13];
      ilc_pkg::OFS_CALC_CHECKSUM: rdata_next = calc_reg;
      ilc_pkg::OFS_LANE1_ID: rdata_next = lane1_received_identifier;
      ilc_pkg::OFS_LANE_CODE: rdata_next = {3'h0, oct_reg[3][4:0]};
      ilc_pkg::OFS_FRAME_OCTETS: rdata_next = oct_reg[4];
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK.reg_rdata <= 8'h00;
      LINK.reg_ack <= 1'b0;
    end else begin
      LINK.reg_ack <= LINK.reg_rd;
      if (LINK.reg_rd) begin
        LINK.reg_rdata <= rdata_next;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/ilc_transmitter.sv
`default_nettype none
module ilc_transmitter (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Link side.
  ilc_link_if.tx LINK
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_READ = 3'b100
  } ilc_state_t;

  ilc_state_t state_reg;
  logic [31:0] cfg_reg [0:2];
  logic [3:0] idx_reg;
  logic mode_reg;
  logic [7:0] sum_reg;
  logic [7:0] add_next;
  logic [7:0] rdata_reg;
  logic [7:0] oct_next;
  logic [7:0] lid1_next;
  logic acc;
  logic go_send;
  logic go_read;

  assign acc = PSEL && PENABLE && PREADY;
  assign go_send = acc && PWRITE && PADDR == ilc_pkg::APB_CTRL && PWDATA[0];
  assign go_read = acc && PWRITE && PADDR == ilc_pkg::APB_CTRL && PWDATA[1];

  // Octets 0..12 come from three config words; octet 13 is the sum field.
  always_comb begin
    oct_next = 8'h00;
    lid1_next = {3'h0, cfg_reg[2][20:16]};
    if (idx_reg < 4'h4) begin
      oct_next = cfg_reg[0][8*idx_reg[1:0] +: 8];
    end else if (idx_reg < 4'h8) begin
      oct_next = cfg_reg[1][8*idx_reg[1:0] +: 8];
    end else if (idx_reg < 4'hC) begin
      oct_next = cfg_reg[2][8*idx_reg[1:0] +: 8];
    end else if (idx_reg == 4'hC) begin
      oct_next = cfg_reg[2][31:24];
    end else begin
      oct_next = sum_reg;
    end
    if (idx_reg == 4'h7) begin
      oct_next[7:6] = 2'h0;
    end
    if (idx_reg == 4'hA) begin
      oct_next[4:0] = 5'h00;
    end
    // The sum is built from the octets as sent, so forced fields count as zero.
    add_next = oct_next;
    if (!mode_reg) begin
      case (idx_reg)
        4'h2: add_next = 8'(oct_next[4:0]) + 8'(oct_next[5]) + 8'(oct_next[6]);
        4'h3, 4'hA: add_next = 8'(oct_next[7]) + 8'(oct_next[4:0]);
        4'h5: add_next = 8'(oct_next[4:0]);
        4'h7: add_next = 8'(oct_next[7:6]) + 8'(oct_next[4:0]);
        4'h8, 4'h9: add_next = 8'(oct_next[7:5]) + 8'(oct_next[4:0]);
        default: add_next = oct_next;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 3; i++) begin
        cfg_reg[i] <= 32'h00000000;
      end
    end else if (acc && PWRITE && state_reg == ST_IDLE) begin
      if (PADDR == ilc_pkg::APB_CFG0) cfg_reg[0] <= PWDATA;
      if (PADDR == ilc_pkg::APB_CFG1) cfg_reg[1] <= PWDATA;
      if (PADDR == ilc_pkg::APB_CFG2) cfg_reg[2] <= PWDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      idx_reg <= 4'h0;
      mode_reg <= 1'b0;
      sum_reg <= 8'h00;
      rdata_reg <= 8'h00;
      LINK.lane0_valid <= 1'b0;
      LINK.lane0_start <= 1'b0;
      LINK.lane0_octet <= 8'h00;
      LINK.lane1_valid <= 1'b0;
      LINK.lane1_start <= 1'b0;
      LINK.lane1_octet <= 8'h00;
      LINK.reg_addr <= 12'h000;
      LINK.reg_rd <= 1'b0;
    end else begin
      LINK.reg_rd <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          LINK.lane0_valid <= 1'b0;
          LINK.lane1_valid <= 1'b0;
          if (go_send) begin
            state_reg <= ST_SEND;
            idx_reg <= 4'h0;
            mode_reg <= PWDATA[2];
            sum_reg <= 8'h00;
          end else if (go_read) begin
            state_reg <= ST_READ;
            LINK.reg_addr <= PWDATA[27:16];
            LINK.reg_rd <= 1'b1;
          end
        end
        ST_SEND: begin
          LINK.lane0_valid <= 1'b1;
          LINK.lane1_valid <= 1'b1;
          LINK.lane0_start <= (idx_reg == 4'h0);
          LINK.lane1_start <= (idx_reg == 4'h0);
          LINK.lane0_octet <= oct_next;
          LINK.lane1_octet <= (idx_reg == ilc_pkg::OCT_LID) ? lid1_next : oct_next;
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg < 4'hB) sum_reg <= sum_reg + add_next;
          if (idx_reg == ilc_pkg::OCT_FCHK) state_reg <= ST_IDLE;
        end
        ST_READ: begin
          if (LINK.reg_ack) begin
            rdata_reg <= LINK.reg_rdata;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // APB answers with zero wait states once the setup phase is seen.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          ilc_pkg::APB_CFG0: PRDATA <= cfg_reg[0];
          ilc_pkg::APB_CFG1: PRDATA <= cfg_reg[1];
          ilc_pkg::APB_CFG2: PRDATA <= cfg_reg[2];
          ilc_pkg::APB_STATUS: PRDATA <= {29'h0, state_reg};
          ilc_pkg::APB_RDATA: PRDATA <= {24'h0, rdata_reg};
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/ilc_link_chk.sv
`default_nettype none
module ilc_link_chk (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Lane 0 and the register port.
  input wire logic lane0_valid,
  input wire logic lane0_start,
  input wire logic [7:0] lane0_octet,
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  // Receiver status.
  input wire logic CAPTURE_DONE,
  input wire logic CHECKSUM_OK
);
  logic [3:0] idx_reg;
  logic [3:0] idx;
  assign idx = lane0_start ? 4'h0 : idx_reg;
  // Octet position, so that per-octet field rules can be checked on the wire.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idx_reg <= 4'h0;
    end else if (lane0_valid) begin
      idx_reg <= idx + 4'h1;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  property p_ack;
    reg_rd |=> reg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("read not acknowledged");
  property p_ack_cause;
    reg_ack |-> $past(reg_rd);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray acknowledge");
  property p_k;
    reg_ack && $past(reg_addr) == 12'h405 |-> reg_rdata inside {8'h00, 8'h0F, 8'h1F};
  endproperty
  a_k: assert property (p_k) else $error("bad multiframe code");
  property p_m;
    reg_ack && $past(reg_addr) == 12'h406 |-> reg_rdata inside {8'h00, 8'h01};
  endproperty
  a_m: assert property (p_m) else $error("bad converter code");
  property p_lid;
    reg_ack && $past(reg_addr) == 12'h412 |-> reg_rdata[7:5] == 3'h0;
  endproperty
  a_lid: assert property (p_lid) else $error("identifier upper bits set");
  property p_cs;
    lane0_valid && idx == 4'h7 |-> lane0_octet[7:6] == 2'h0;
  endproperty
  a_cs: assert property (p_cs) else $error("control bits not zero");
  property p_cf;
    lane0_valid && idx == 4'hA |-> lane0_octet[4:0] == 5'h00;
  endproperty
  a_cf: assert property (p_cf) else $error("control words not zero");
  property p_len;
    lane0_valid && lane0_start |=> (lane0_valid && !lane0_start)[*8] ##1
      (lane0_valid && !lane0_start)[*5];
  endproperty
  a_len: assert property (p_len) else $error("sequence length wrong");
  property p_done;
    lane0_valid && idx == 4'hD |-> ##[1:3] CAPTURE_DONE;
  endproperty
  a_done: assert property (p_done) else $error("capture not done");
  c_frame: cover property (lane0_valid && lane0_start);
  c_ok: cover property ($rose(CAPTURE_DONE) && CHECKSUM_OK);
  c_lid: cover property (reg_ack && $past(reg_addr) == 12'h412);
endmodule
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST_N, CHECKSUM_MODE, CAPTURE_DONE, CHECKSUM_OK, done_d;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, seed;
  logic [7:0] o [14];
  logic [4:0] lid;
  logic [7:0] calc;
  logic [32:0] exp_q [$];
  string nam_q [$];
  logic ok_q [$];
  int num_errors, checks, cyc;
  ilc_link_if link();
  ilc_receiver u_ilc_receiver (.CLK(CLK), .RST_N(RST_N), .CHECKSUM_MODE(CHECKSUM_MODE),
    .LINK(link), .CAPTURE_DONE(CAPTURE_DONE), .CHECKSUM_OK(CHECKSUM_OK));
  ilc_transmitter u_ilc_transmitter (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .LINK(link));
  ilc_link_chk u_ilc_link_chk (.CLK(CLK), .RST_N(RST_N), .lane0_valid(link.lane0_valid),
    .lane0_start(link.lane0_start), .lane0_octet(link.lane0_octet), .reg_addr(link.reg_addr),
    .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
    .CAPTURE_DONE(CAPTURE_DONE), .CHECKSUM_OK(CHECKSUM_OK));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [7:0] sum(input logic m);
    logic [7:0] s;
    s = o[0] + o[1] + o[2][4:0] + o[2][5] + o[2][6] + o[3][7] + o[3][4:0] + o[4] + o[5][4:0];
    s = s + o[6] + o[7][7:6] + o[7][4:0] + o[8][7:5] + o[8][4:0] + o[9][7:5] + o[9][4:0];
    s = s + o[10][7] + o[10][4:0];
    if (m) begin
      s = 8'h00;
      for (int j = 0; j < 11; j++) s = s + o[j];
    end
    return s;
  endfunction
  task automatic compare(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Requests are held until PREADY is sampled high; read data is taken at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic c, input logic [31:0] e, output logic [31:0] r);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    if (!w) begin
      exp_q.push_back({c, e});
      nam_q.push_back($sformatf("reg %h", a));
    end
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Control writes made while a transfer is running are dropped, so wait for idle first.
  task automatic idle();
    logic [31:0] r;
    r = 32'h0;
    for (int n = 0; n < 60 && r !== 32'h1; n++) apb(1'b0, 12'h010, 32'h0, 1'b0, 32'h0, r);
  endtask
  task automatic rd_rx(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] r;
    idle();
    apb(1'b1, 12'h000, {4'h0, a, 16'h0002}, 1'b0, 32'h0, r);
    idle();
    apb(1'b0, 12'h014, 32'h0, 1'b1, {24'h0, e}, r);
  endtask
  task automatic regs();
    logic [7:0] e;
    for (int j = 0; j < 10; j++) begin
      e = j < 8 ? o[5 + j] : (j == 8 ? o[13] : calc);
      rd_rx(12'h405 + 12'(j), e);
    end
    rd_rx(12'h412, {3'h0, lid});
    rd_rx(12'h403, {3'h0, o[3][4:0]});
    rd_rx(12'h404, o[4]);
  endtask
  task automatic send(input int i);
    logic [31:0] r;
    logic [1:0] cs;
    logic txm;
    r = rnd();
    o[0] = r[7:0];
    o[1] = r[15:8];
    o[2] = r[23:16];
    cs = r[25:24];
    o[3] = {r[27], 2'h0, 5'((1 << i) - 1)};
    o[4] = 8'(((1 << i) - 1) & 3);
    o[5] = {3'h0, i[0] ? ilc_pkg::K_32 : ilc_pkg::K_16};
    o[6] = i[1] ? ilc_pkg::M_COMPLEX : ilc_pkg::M_REAL;
    r = rnd();
    o[7] = {3'h0, r[4:0]};
    o[8] = {i[0] ? ilc_pkg::SUBCLASS_1 : ilc_pkg::SUBCLASS_0, r[12:8]};
    o[9] = {i[1] ? ilc_pkg::VERSION_B : ilc_pkg::VERSION_A, r[20:16]};
    lid = r[28:24];
    o[10] = {r[29], 7'h00};
    r = rnd();
    o[11] = r[7:0];
    o[12] = r[7:0];
    // The last pass sends with the other checksum method, so a mismatch must show.
    txm = (i == 3) ? 1'b0 : i[0];
    o[13] = sum(txm);
    calc = sum(i[0]);
    ok_q.push_back(o[13] == calc);
    CHECKSUM_MODE <= i[0];
    idle();
    apb(1'b1, 12'h004, {o[3], o[2], o[1], o[0]}, 1'b0, 32'h0, r);
    apb(1'b1, 12'h008, {cs, 1'b0, o[7][4:0], o[6], o[5], o[4]}, 1'b0, 32'h0, r);
    apb(1'b1, 12'h00C, {o[11], o[10][7], 2'h0, lid, o[9], o[8]}, 1'b0, 32'h0, r);
    apb(1'b0, 12'h004, 32'h0, 1'b1, {o[3], o[2], o[1], o[0]}, r);
    apb(1'b1, 12'h000, {29'h0, txm, 2'b01}, 1'b0, 32'h0, r);
    for (int n = 0; n < 60 && link.lane0_start !== 1'b1; n++) @(posedge CLK);
    for (int n = 0; n < 60 && CAPTURE_DONE !== 1'b0; n++) @(posedge CLK);
    for (int n = 0; n < 60 && CAPTURE_DONE !== 1'b1; n++) @(posedge CLK);
    compare("capture done", 32'h1, {31'h0, CAPTURE_DONE});
  endtask
  task test_done();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Results are matched in arrival order against the notes left by the driver.
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && exp_q.size() > 0) begin
      if (exp_q[0][32]) compare(nam_q[0], exp_q[0][31:0], PRDATA);
      void'(exp_q.pop_front());
      void'(nam_q.pop_front());
    end
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      compare("pslverr", 32'h0, {31'h0, PSLVERR});
    end
    if (CAPTURE_DONE === 1'b1 && done_d !== 1'b1 && ok_q.size() > 0) begin
      compare("checksum ok", {31'h0, ok_q.pop_front()}, {31'h0, CHECKSUM_OK});
    end
    done_d <= CAPTURE_DONE;
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    logic [31:0] r;
    {RST_N, CHECKSUM_MODE, PSEL, PENABLE, PWRITE} = 5'h00;
    calc = 8'h00;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    seed = 32'h58EB52BE;
    lid = 5'h00;
    foreach (o[j]) o[j] = 8'h00;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    regs();
    apb(1'b0, 12'h020, 32'h0, 1'b1, 32'h0, r);
    for (int i = 0; i < 4; i++) begin
      send(i);
      regs();
    end
    test_done();
  end
endmodule
`default_nettype wire
